// ==== verilog/csel_consts.svh ====
// constants of the clock mode and source select block
`ifndef CSEL_CONSTS_SVH
`define CSEL_CONSTS_SVH

// ==========================================================
// register addresses (byte addresses, 8-bit accesses)
`define CSEL_ADDR_PIN_MODE 32'h4002_0400
`define CSEL_ADDR_CLK_SEL 32'h4002_0404

// ==========================================================
// reset values
`define CSEL_PIN_MODE_RST 8'h00
`define CSEL_CLK_SEL_RST 8'h00

// ==========================================================
// oscillator pin mode register fields
`define CSEL_MAIN_MODE_HI 7
`define CSEL_MAIN_MODE_LO 6
`define CSEL_SUB_MODE_HI 5
`define CSEL_SUB_MODE_LO 4
`define CSEL_SUB_DRIVE_HI 2
`define CSEL_SUB_DRIVE_LO 1
`define CSEL_FREQ_RANGE_BIT 0

// ==========================================================
// system clock select register fields
`define CSEL_CPU_STATUS_BIT 7
`define CSEL_CPU_REQ_BIT 6
`define CSEL_MAIN_STATUS_BIT 5
`define CSEL_MAIN_REQ_BIT 4

// ==========================================================
// pin mode and drive codes
`define CSEL_MODE_OSC 2'h1
`define CSEL_MODE_EXT 2'h3
`define CSEL_DRIVE_LOW_POWER 2'h0
`define CSEL_DRIVE_BANNED 2'h3

// ==========================================================
// switchover dead time
`define CSEL_CLK_PERIOD_NS 8
`define CSEL_SWITCH_GAP_NS 16

`endif

// ==== verilog/csel_pkg.sv ====
// types of the clock mode and source select block
package csel_pkg;

  // ==========================================================
  // oscillator pin mode register image
  typedef struct packed {
    logic [1:0] main_mode;
    logic [1:0] sub_mode;
    logic rsvd;
    logic [1:0] sub_drive;
    logic main_freq_range;
  } csel_pin_mode_t;

  // ==========================================================
  // decoded pin usage for one oscillator pair
  typedef struct packed {
    logic osc_en;
    logic ext_in_en;
  } csel_pin_use_t;

  // ==========================================================
  // switchover sequencer states
  typedef enum logic {
    CSEL_SW_IDLE,
    CSEL_SW_GAP
  } csel_sw_state_t;

endpackage

// ==== verilog/csel_switch.sv ====
// glitch-free switchover sequencer for one clock multiplexer
`include "csel_consts.svh"

module csel_switch
  import csel_pkg::*;
(
  // clock and control
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // selection
  input wire logic req_i,
  output logic sel_o,
  output logic busy_o
);

  localparam int GapCyc = (`CSEL_SWITCH_GAP_NS + `CSEL_CLK_PERIOD_NS - 1) / `CSEL_CLK_PERIOD_NS;
  localparam logic [1:0] GapLast = 2'(GapCyc - 1);

  csel_sw_state_t state_q;
  logic [1:0] cnt_q;

  // ==========================================================
  // old source is dropped, both held off for the gap, then new taken
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= CSEL_SW_IDLE;
      cnt_q <= 2'h0;
      sel_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      case (state_q)
        CSEL_SW_IDLE:
        begin
          if (req_i != sel_o)
          begin
            state_q <= CSEL_SW_GAP;
            cnt_q <= 2'h0;
            busy_o <= 1'b1;
          end
        end
        CSEL_SW_GAP:
        begin
          if (cnt_q == GapLast)
          begin
            // status follows only once the new source is live (see R20)
            state_q <= CSEL_SW_IDLE;
            sel_o <= req_i;
            busy_o <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        default:
        begin
          state_q <= CSEL_SW_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  property p_sel_after_gap;
    @(posedge clk_i) disable iff (reset_i)
    $changed(sel_o) |-> $past(busy_o);
  endproperty
  a_sel_after_gap: assert property (p_sel_after_gap) else $error("selection moved without a gap"); // see R20

  property p_gap_start;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && !busy_o && (req_i != sel_o) |=> busy_o && $stable(sel_o);
  endproperty
  a_gap_start: assert property (p_gap_start) else $error("request change did not open a gap"); // see R20

  property p_gap_bound;
    @(posedge clk_i) disable iff (reset_i)
    busy_o |-> cnt_q <= GapLast;
  endproperty
  a_gap_bound: assert property (p_gap_bound) else $error("gap counter overran");

endmodule

// ==== verilog/csel_top.sv ====
// oscillator pin mode and system clock source select registers
`include "csel_consts.svh"

// What this block does
// (R1) pin mode register accepts only first write
// (R2) sub fields cleared only by power-on
// (R3) main pins: port, crystal, or external clock
// (R4) sub pins: port, crystal, or external clock
// (R5) sub drive: low, normal, ultra-low; 11 banned
// (R6) software sets range bit above 10 MHz
// (R7) software writes 00H even when default
// (R8) software sets mode before starting oscillators
// (R9) software sets gains while internal clock runs
// (R10) software times sub crystal settling
// (R11) system 32 MHz, crystal 20 MHz maximum
// (R12) bit 7 reports current cpu clock
// (R13) bit 6 requests cpu clock source
// (R14) bit 5 reports current main source
// (R15) bit 4 requests main clock source
// (R16) bits 7,5 read-only; 3:0 written zero
// (R17) software keeps main source while sub selected
// (R18) cpu clock change moves peripheral clock too
// (R19) halt bit stops main oscillator input
// (R20) status updates after glitch-free switchover
module csel_top
  import csel_pkg::*;
(
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic ce_i,
  // 8-bit register access
  input wire logic [31:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // oscillator stop control bit from the stop register
  input wire logic main_osc_halt_i,
  // main oscillator pins
  output logic main_osc_en_o,
  output logic main_ext_in_en_o,
  output logic main_osc_run_o,
  output logic main_freq_range_o,
  // subsystem oscillator pins
  output logic sub_osc_en_o,
  output logic sub_ext_in_en_o,
  output logic [1:0] sub_drive_o,
  // clock multiplexer controls
  output logic cpu_on_sub_o,
  output logic main_on_fast_ext_o,
  output logic clk_hold_o
);

  // ==========================================================
  // register state
  csel_pin_mode_t pin_mode_q;
  logic pin_mode_locked_q;
  logic cpu_clock_request_q;
  logic main_source_request_q;
  logic cpu_clock_status;
  logic main_source_status;
  logic cpu_busy;
  logic main_busy;
  logic wr_pin_mode;
  logic wr_clk_sel;
  logic rd_pin_mode;
  logic rd_clk_sel;
  csel_pin_use_t main_use;
  csel_pin_use_t sub_use;
  logic [7:0] clk_sel_view;

  // reset images split into fields without silent truncation
  localparam csel_pin_mode_t PinModeRst = `CSEL_PIN_MODE_RST;
  localparam logic [7:0] ClkSelRst = `CSEL_CLK_SEL_RST;

  assign wr_pin_mode = ce_i && wr_i && (addr_i == `CSEL_ADDR_PIN_MODE);
  assign wr_clk_sel = ce_i && wr_i && (addr_i == `CSEL_ADDR_CLK_SEL);
  assign rd_pin_mode = rd_i && (addr_i == `CSEL_ADDR_PIN_MODE);
  assign rd_clk_sel = rd_i && (addr_i == `CSEL_ADDR_CLK_SEL);

  // ==========================================================
  // pin mode register: one write per reset, any number of reads
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_mode_locked_q <= 1'b0;
    end
    else if (wr_pin_mode)
    begin
      pin_mode_locked_q <= 1'b1; // see R1
    end
  end

  // main fields follow every reset; sub fields survive warm resets
  // but sub_osc_en_o, sub_ext_in_en_o and sub_drive_o still clear while reset_i is high
  always_ff @(posedge clk_i)
  begin
    if (reset_i || por_i)
    begin
      if (reset_i)
      begin
        pin_mode_q.main_mode <= PinModeRst.main_mode;
        pin_mode_q.rsvd <= 1'b0;
        pin_mode_q.main_freq_range <= PinModeRst.main_freq_range;
      end
      if (por_i)
      begin
        pin_mode_q.sub_mode <= PinModeRst.sub_mode; // see R2
        pin_mode_q.sub_drive <= PinModeRst.sub_drive;
      end
    end
    else if (wr_pin_mode && !pin_mode_locked_q)
    begin
      pin_mode_q.main_mode <= wdata_i[`CSEL_MAIN_MODE_HI:`CSEL_MAIN_MODE_LO]; // see R1
      pin_mode_q.sub_mode <= wdata_i[`CSEL_SUB_MODE_HI:`CSEL_SUB_MODE_LO]; // see R1
      // bit 3 is fixed at zero
      pin_mode_q.rsvd <= 1'b0;
      pin_mode_q.sub_drive <= wdata_i[`CSEL_SUB_DRIVE_HI:`CSEL_SUB_DRIVE_LO];
      pin_mode_q.main_freq_range <= wdata_i[`CSEL_FREQ_RANGE_BIT];
    end
  end

  // ==========================================================
  // system clock select requests
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cpu_clock_request_q <= ClkSelRst[`CSEL_CPU_REQ_BIT];
      main_source_request_q <= ClkSelRst[`CSEL_MAIN_REQ_BIT];
    end
    else if (wr_clk_sel)
    begin
      // status bits and low nibble are not stored (see R16)
      cpu_clock_request_q <= wdata_i[`CSEL_CPU_REQ_BIT]; // see R13
      main_source_request_q <= wdata_i[`CSEL_MAIN_REQ_BIT]; // see R15
    end
  end

  // ==========================================================
  // switchover sequencers; one cpu mux feeds cpu and most peripherals alike
  csel_switch u_cpu_switch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .req_i(cpu_clock_request_q),
    .sel_o(cpu_clock_status),
    .busy_o(cpu_busy)
  ); // see R18

  csel_switch u_main_switch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .req_i(main_source_request_q),
    .sel_o(main_source_status),
    .busy_o(main_busy)
  ); // see R20

  // ==========================================================
  // pin usage decode; codes 00 and 10 leave the pins as ports
  always_comb
  begin
    main_use.osc_en = (pin_mode_q.main_mode == `CSEL_MODE_OSC); // see R3
    main_use.ext_in_en = (pin_mode_q.main_mode == `CSEL_MODE_EXT); // see R3
    sub_use.osc_en = (pin_mode_q.sub_mode == `CSEL_MODE_OSC); // see R4
    sub_use.ext_in_en = (pin_mode_q.sub_mode == `CSEL_MODE_EXT); // see R4
  end

  always_comb
  begin
    clk_sel_view = 8'h00;
    clk_sel_view[`CSEL_CPU_STATUS_BIT] = cpu_clock_status; // see R12
    clk_sel_view[`CSEL_CPU_REQ_BIT] = cpu_clock_request_q;
    clk_sel_view[`CSEL_MAIN_STATUS_BIT] = main_source_status; // see R14
    clk_sel_view[`CSEL_MAIN_REQ_BIT] = main_source_request_q;
  end

  // ==========================================================
  // read data, unmapped addresses return zero
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (ce_i)
    begin
      if (rd_pin_mode)
      begin
        rdata_o <= pin_mode_q;
      end
      else if (rd_clk_sel)
      begin
        rdata_o <= clk_sel_view;
      end
      else
      begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================================
  // oscillator and multiplexer controls
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      main_osc_en_o <= 1'b0;
      main_ext_in_en_o <= 1'b0;
      main_osc_run_o <= 1'b0;
      main_freq_range_o <= 1'b0;
      sub_osc_en_o <= 1'b0;
      sub_ext_in_en_o <= 1'b0;
      sub_drive_o <= `CSEL_DRIVE_LOW_POWER;
      cpu_on_sub_o <= 1'b0;
      main_on_fast_ext_o <= 1'b0;
      clk_hold_o <= 1'b0;
    end
    else if (ce_i)
    begin
      main_osc_en_o <= main_use.osc_en;
      main_ext_in_en_o <= main_use.ext_in_en;
      main_osc_run_o <= !main_osc_halt_i && (main_use.osc_en || main_use.ext_in_en); // see R19
      main_freq_range_o <= pin_mode_q.main_freq_range;
      sub_osc_en_o <= sub_use.osc_en;
      sub_ext_in_en_o <= sub_use.ext_in_en;
      // banned drive code falls back to the low-power setting (see R5)
      if (pin_mode_q.sub_drive == `CSEL_DRIVE_BANNED)
      begin
        sub_drive_o <= `CSEL_DRIVE_LOW_POWER;
      end
      else
      begin
        sub_drive_o <= pin_mode_q.sub_drive;
      end
      cpu_on_sub_o <= cpu_clock_status;
      main_on_fast_ext_o <= main_source_status;
      clk_hold_o <= cpu_busy || main_busy;
    end
  end

  // ==========================================================
  // checks
  property p_lock_holds;
    @(posedge clk_i) disable iff (reset_i || por_i)
    pin_mode_locked_q && wr_pin_mode |=> $stable(pin_mode_q);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked pin mode register changed"); // see R1

  property p_first_write;
    @(posedge clk_i) disable iff (reset_i || por_i)
    !pin_mode_locked_q && wr_pin_mode |=> pin_mode_q.main_mode == $past(wdata_i[7:6]) && pin_mode_locked_q;
  endproperty
  a_first_write: assert property (p_first_write) else $error("first pin mode write not taken"); // see R1

  property p_sub_keep;
    @(posedge clk_i)
    reset_i && !por_i |=> pin_mode_q.sub_mode == $past(pin_mode_q.sub_mode);
  endproperty
  a_sub_keep: assert property (p_sub_keep) else $error("sub mode lost on warm reset"); // see R2

  property p_por_clear;
    @(posedge clk_i)
    por_i |=> pin_mode_q.sub_mode == 2'h0 && pin_mode_q.sub_drive == 2'h0;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("power-on did not clear sub fields"); // see R2

  property p_drive_legal;
    @(posedge clk_i) disable iff (reset_i)
    sub_drive_o != 2'h3;
  endproperty
  a_drive_legal: assert property (p_drive_legal) else $error("banned drive code reached the pad"); // see R5

  property p_ext_decode;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && pin_mode_q.main_mode == 2'h3 ##1 $stable(pin_mode_q) |-> main_ext_in_en_o && !main_osc_en_o;
  endproperty
  a_ext_decode: assert property (p_ext_decode) else $error("main external clock mode misdecoded"); // see R3

  property p_sub_decode;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && pin_mode_q.sub_mode == 2'h1 ##1 $stable(pin_mode_q) |-> sub_osc_en_o && !sub_ext_in_en_o;
  endproperty
  a_sub_decode: assert property (p_sub_decode) else $error("sub crystal mode misdecoded"); // see R4

  property p_halt_stops;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && main_osc_halt_i |=> !main_osc_run_o;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("main oscillator ran while halted"); // see R19

  property p_status_read;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && rd_clk_sel |=> rdata_o[7] == $past(cpu_clock_status) && rdata_o[5] == $past(main_source_status)
      && rdata_o[3:0] == 4'h0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("clock select read mismatch"); // see R12

  property p_status_only;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && wr_clk_sel && !cpu_busy && (cpu_clock_status == cpu_clock_request_q) |=> $stable(cpu_clock_status);
  endproperty
  a_status_only: assert property (p_status_only) else $error("write moved read-only status"); // see R16

endmodule

// ==== bench/tb_csel_top.sv ====
// self-checking testbench of the clock mode and source select block
`include "csel_consts.svh"

module tb_csel_top
  import csel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic por_i = 1'b1;
  logic ce_i = 1'b1;
  logic [31:0] addr_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic main_osc_halt_i = 1'b1;
  logic [7:0] rdata_o;
  logic main_osc_en_o, main_ext_in_en_o, main_osc_run_o, main_freq_range_o;
  logic sub_osc_en_o, sub_ext_in_en_o;
  logic [1:0] sub_drive_o;
  logic cpu_on_sub_o, main_on_fast_ext_o, clk_hold_o;
  int failures = 0;
  int checked = 0;

  always #4 clk_i = ~clk_i;

  csel_top i_csel_top (
    .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .ce_i(ce_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .main_osc_halt_i(main_osc_halt_i), .main_osc_en_o(main_osc_en_o),
    .main_ext_in_en_o(main_ext_in_en_o), .main_osc_run_o(main_osc_run_o),
    .main_freq_range_o(main_freq_range_o), .sub_osc_en_o(sub_osc_en_o),
    .sub_ext_in_en_o(sub_ext_in_en_o), .sub_drive_o(sub_drive_o),
    .cpu_on_sub_o(cpu_on_sub_o), .main_on_fast_ext_o(main_on_fast_ext_o),
    .clk_hold_o(clk_hold_o)
  );

  // ==========================================================
  // shared tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset(input logic p, input int n);
    @(posedge clk_i);
    reset_i <= 1'b1;
    por_i <= p;
    repeat (n) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data is registered at the taking edge, so look just after it
  task automatic rd(input string name, input logic [31:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(name, rdata_o, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_lock;
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`CSEL_ADDR_PIN_MODE, 8'h80);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd("pin_frozen", `CSEL_ADDR_PIN_MODE, 8'h00);
    wr(`CSEL_ADDR_PIN_MODE, 8'h41);
    settle();
    chk("main_osc_en", main_osc_en_o, 8'h01);
    chk("freq_range", main_freq_range_o, 8'h01);
    wr(`CSEL_ADDR_PIN_MODE, 8'hF6);
    rd("pin_locked", `CSEL_ADDR_PIN_MODE, 8'h41);
    rd("pin_again", `CSEL_ADDR_PIN_MODE, 8'h41);
  endtask

  // every pin mode and drive code, one power-on per code
  task automatic t_modes;
    logic [1:0] c;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      d = {c, c, 1'b0, c, 1'b0};
      do_reset(1'b1, 2);
      main_osc_halt_i <= 1'b1;
      wr(`CSEL_ADDR_PIN_MODE, d);
      main_osc_halt_i <= (c == 2'h3);
      settle();
      chk("main_osc_en", main_osc_en_o, 8'(c == 2'h1));
      chk("main_ext_en", main_ext_in_en_o, 8'(c == 2'h3));
      chk("main_run", main_osc_run_o, 8'(c == 2'h1));
      chk("sub_osc_en", sub_osc_en_o, 8'(c == 2'h1));
      chk("sub_ext_en", sub_ext_in_en_o, 8'(c == 2'h3));
      chk("sub_drive", 8'(sub_drive_o), (c == 2'h3) ? 8'h00 : 8'(c));
      rd("pin_image", `CSEL_ADDR_PIN_MODE, d);
    end
    @(posedge clk_i);
    main_osc_halt_i <= 1'b0;
  endtask

  task automatic t_keep;
    do_reset(1'b1, 2);
    wr(`CSEL_ADDR_PIN_MODE, 8'hF5);
    settle();
    wr(`CSEL_ADDR_CLK_SEL, 8'h40);
    settle();
    do_reset(1'b0, 2);
    #1;
    chk("cpu_after_rst", cpu_on_sub_o, 8'h00);
    rd("sub_kept", `CSEL_ADDR_PIN_MODE, 8'h34);
    rd("sel_rst", `CSEL_ADDR_CLK_SEL, 8'h00);
    do_reset(1'b1, 2);
    rd("sub_cleared", `CSEL_ADDR_PIN_MODE, 8'h00);
  endtask

  // status must trail the request by the whole dead time
  task automatic sw(input logic [7:0] d, input logic [7:0] exp);
    logic pc, pm;
    int n;
    pc = cpu_on_sub_o;
    pm = main_on_fast_ext_o;
    wr(`CSEL_ADDR_CLK_SEL, d);
    n = 0;
    while (clk_hold_o !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("hold_rise", clk_hold_o, 8'h01);
    chk("cpu_mid", cpu_on_sub_o, 8'(pc));
    chk("main_mid", main_on_fast_ext_o, 8'(pm));
    n = 0;
    while (clk_hold_o !== 1'b0 && n < 10)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("hold_fall", clk_hold_o, 8'h00);
    chk("cpu_on_sub", cpu_on_sub_o, 8'(exp[7]));
    chk("main_fast", main_on_fast_ext_o, 8'(exp[5]));
    rd("sel_image", `CSEL_ADDR_CLK_SEL, exp);
  endtask

  // main source only moves while the cpu runs on the main clock
  task automatic t_switch;
    sw(8'h10, 8'h30);
    sw(8'h50, 8'hF0);
    sw(8'h10, 8'h30);
    sw(8'h00, 8'h00);
  endtask

  task automatic t_readonly;
    wr(`CSEL_ADDR_CLK_SEL, 8'hA0);
    settle();
    chk("no_switch", clk_hold_o, 8'h00);
    rd("sel_ro", `CSEL_ADDR_CLK_SEL, 8'h00);
    wr(32'h4002_0408, 8'hFF);
    rd("unmapped", 32'h4002_0408, 8'h00);
    rd("sel_kept", `CSEL_ADDR_CLK_SEL, 8'h00);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    por_i <= 1'b0;
    #1;
    chk("cpu_rst", cpu_on_sub_o, 8'h00);
    rd("pin_rst", `CSEL_ADDR_PIN_MODE, 8'h00);
    rd("sel_rst", `CSEL_ADDR_CLK_SEL, 8'h00);
    t_lock();
    t_modes();
    t_keep();
    t_switch();
    t_readonly();
    end_of_test();
  end

  initial
  begin
    repeat (4000) @(posedge clk_i);
    failures++;
    end_of_test();
  end

endmodule
